// ===== ppl_regs.svh
`ifndef PPL_REGS_SVH
`define PPL_REGS_SVH

// action select codes
`define PPL_ACT_ADDR        2'h0
`define PPL_ACT_DATA        2'h1
`define PPL_ACT_CMD         2'h2
`define PPL_ACT_IDLE        2'h3

// command byte codes
`define PPL_CMD_NOP         8'h00
`define PPL_CMD_CHIP_ERASE  8'h80
`define PPL_CMD_WR_FUSE     8'h40
`define PPL_CMD_WR_LOCK     8'h20
`define PPL_CMD_WR_FLASH    8'h10
`define PPL_CMD_WR_EE       8'h11
`define PPL_CMD_RD_SIG      8'h08
`define PPL_CMD_RD_FUSE     8'h04
`define PPL_CMD_RD_FLASH    8'h02
`define PPL_CMD_RD_EE       8'h03

// page geometry
`define PPL_PAGE_WORDS      5'h10
`define PPL_WORD_IDX_MSB    3
`define PPL_ADDR_HI_BITS    2

// buffering
`define PPL_FIFO_DEPTH      16
`define PPL_FIFO_WIDTH      29

// reset values
`define PPL_RST_CMD         8'h00
`define PPL_RST_BYTE        8'h00
`define PPL_RST_WORD        16'hFFFF

`endif

// ===== ppl_pkg.sv
`default_nettype none

package ppl_pkg;

   typedef enum logic [4:0] {
      PPL_ST_IDLE  = 5'h01,
      PPL_ST_PAGE  = 5'h02,
      PPL_ST_ERASE = 5'h04,
      PPL_ST_DRAIN = 5'h08,
      PPL_ST_LOCK  = 5'h10
   } ppl_state_t;

   typedef enum logic [2:0] {
      PPL_OP_FLASH_WORD  = 3'h0,
      PPL_OP_ERASE_FLASH = 3'h1,
      PPL_OP_ERASE_EE    = 3'h2,
      PPL_OP_LOCK_CLEAR  = 3'h3,
      PPL_OP_FUSE_LO     = 3'h4,
      PPL_OP_FUSE_HI     = 3'h5,
      PPL_OP_LOCK_WR     = 3'h6,
      PPL_OP_EE_BYTE     = 3'h7
   } ppl_op_t;

endpackage : ppl_pkg

`default_nettype wire

// ===== ppl_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module ppl_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              push;
   wire              pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : ppl_fifo

`default_nettype wire

// ===== ppl_loader.sv
// Functional notes
// [RULE1] strobe with action 00 loads address low or high byte per byte select
// [RULE2] strobe with action 01 loads data low or high byte per byte select
// [RULE3] strobe with action 10 captures the data bus as the command
// [RULE4] action 11 does nothing; without strobe all registers hold
// [RULE5] programmer drives second byte select only for fuse reads without strobe
// [RULE6] command 80h is chip erase; write pulse starts it, busy until done
// [RULE7] 10h is program page write, 11h is data memory write
// [RULE8] 04h reads fuses and lock, 40h writes fuses, 20h writes lock
// [RULE9] 08h reads signature/calibration, 02h program memory, 03h data memory
// [RULE10] programmer finishes entry within 64 ms, waits 60 us after supply
// [RULE11] programmer waits 20 us, applies high voltage, waits 10 us
// [RULE12] programmer then sets clock fuses for internal 8 MHz mode
// [RULE13] programmer erases chip before changing fuses when locked
// [RULE14] mode ends on power down or reset pin at zero; reentry needed
// [RULE15] command and address stay loaded across operations
// [RULE16] programmer reloads high address only for a new 256 window
// [RULE17] programmer may skip writing FFh after erase
// [RULE18] erase clears program, data memory, then lock bits; fuses kept
// [RULE19] data preserve fuse programmed keeps data memory through erase
// [RULE20] programmer erases before reprogramming either memory
// [RULE21] loaded words go to a page buffer programmed in one operation
// [RULE22] high address byte comes from data bus, range 00h to 03h
// [RULE23] low address bits pick word, higher bits pick page
// [RULE24] write pulse with byte select low programs page, busy until done
// [RULE25] ready/busy low while programming, high when ready
// [RULE26] page is 16 words, index bits 3:0, 64 pages on bits 9:4
`timescale 1ns/1ps
`default_nettype none
`include "ppl_regs.svh"

module ppl_loader
   import ppl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   // programming pins
   input  wire logic        prog_mode_pin,
   input  wire logic        load_strobe_pin,
   input  wire logic        action_select_hi,
   input  wire logic        action_select_lo,
   input  wire logic        byte_select_first,
   input  wire logic        write_pulse_n,
   input  wire logic        output_enable_n,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  data_out,
   output logic             data_oe_n,
   output logic             ready_busy_flag,
   // fuse state
   input  wire logic        keep_nvdata_fuse,
   // memory read port
   output logic      [9:0]  rd_addr,
   output logic             rd_high,
   output logic             rd_sel_second,
   output logic      [7:0]  cmd_code,
   input  wire logic [7:0]  rd_data,
   // memory write port
   output logic             nvm_valid,
   input  wire logic        nvm_ready,
   output logic      [2:0]  nvm_op,
   output logic      [9:0]  nvm_addr,
   output logic      [15:0] nvm_data,
   input  wire logic        nvm_idle
);

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   localparam int NSYNC = 15;

   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   logic             strobe_d;
   logic             wr_d;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {prog_mode_pin, load_strobe_pin, action_select_hi, action_select_lo,
                    byte_select_first, write_pulse_n, output_enable_n, data_in};
         sync_b <= sync_a;
      end
   end

   wire       in_mode  = sync_b[14];
   wire       strobe_s = sync_b[13];
   wire [1:0] action   = sync_b[12:11];
   wire       bs_first = sync_b[10];
   wire       wr_n_s   = sync_b[9];
   wire       oe_n_s   = sync_b[8];
   wire [7:0] bus      = sync_b[7:0];
   // second byte select shares the action high pin
   wire       bs_second = sync_b[12];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strobe_d <= 1'b0;
         wr_d     <= 1'b1;
      end else begin
         strobe_d <= strobe_s;
         wr_d     <= wr_n_s;
      end
   end

   // leaving programming mode clears everything but the pin synchronisers and edge flops, like a reset
   wire clr       = !rst_n || !in_mode; // [RULE14]
   wire strobe_up = strobe_s && !strobe_d && in_mode;
   wire wr_fall   = !wr_n_s && wr_d && in_mode;

   // ==========================================================
   // command, address and data registers
   // ==========================================================
   logic [7:0]  cmd;
   logic [7:0]  addr_lo;
   logic [`PPL_ADDR_HI_BITS-1:0] addr_hi;
   logic [7:0]  data_lo;
   logic [7:0]  data_hi;

   // action 11 and no strobe leave every register alone
   wire ld_addr = strobe_up && (action == `PPL_ACT_ADDR); // [RULE1] [RULE4]
   wire ld_data = strobe_up && (action == `PPL_ACT_DATA); // [RULE2] [RULE4]
   wire ld_cmd  = strobe_up && (action == `PPL_ACT_CMD);  // [RULE3] [RULE4]

   // command decode
   wire is_erase    = (cmd == `PPL_CMD_CHIP_ERASE); // [RULE6]
   wire is_wr_flash = (cmd == `PPL_CMD_WR_FLASH);   // [RULE7]
   wire is_wr_ee    = (cmd == `PPL_CMD_WR_EE);      // [RULE7]
   wire is_wr_fuse  = (cmd == `PPL_CMD_WR_FUSE);    // [RULE8]
   wire is_wr_lock  = (cmd == `PPL_CMD_WR_LOCK);    // [RULE8]
   wire is_rd_fuse  = (cmd == `PPL_CMD_RD_FUSE);    // [RULE8]
   wire is_rd_sig   = (cmd == `PPL_CMD_RD_SIG);     // [RULE9]
   wire is_rd_flash = (cmd == `PPL_CMD_RD_FLASH);   // [RULE9]
   wire is_rd_ee    = (cmd == `PPL_CMD_RD_EE);      // [RULE9]
   wire is_read     = is_rd_fuse || is_rd_sig || is_rd_flash || is_rd_ee;

   // held until reloaded, so one load serves many locations
   always_ff @(posedge clk) begin
      if (clr) begin
         cmd <= `PPL_RST_CMD;
      end else if (ld_cmd) begin
         cmd <= bus; // [RULE3] [RULE15]
      end
   end

   always_ff @(posedge clk) begin
      if (clr) begin
         addr_lo <= `PPL_RST_BYTE;
         addr_hi <= '0;
      end else if (ld_addr && !bs_first) begin
         addr_lo <= bus; // [RULE1] [RULE15]
      end else if (ld_addr && bs_first) begin
         // only 00h..03h is meaningful; upper bits dropped
         addr_hi <= bus[`PPL_ADDR_HI_BITS-1:0]; // [RULE22]
      end
   end

   always_ff @(posedge clk) begin
      if (clr) begin
         data_lo <= `PPL_RST_BYTE;
         data_hi <= `PPL_RST_BYTE;
      end else if (ld_data && !bs_first) begin
         data_lo <= bus; // [RULE2]
      end else if (ld_data && bs_first) begin
         data_hi <= bus; // [RULE2]
      end
   end

   // ==========================================================
   // page buffer
   // ==========================================================
   logic [15:0] page_buf [`PPL_FIFO_DEPTH];

   wire [`PPL_WORD_IDX_MSB:0] page_word_index   = addr_lo[`PPL_WORD_IDX_MSB:0];          // [RULE26]
   // upper low-byte bits join the high byte to form the page
   wire [5:0]                 page_number_index = {addr_hi, addr_lo[7:4]};               // [RULE23] [RULE26]
   // a word is latched when its high byte arrives
   wire                       buf_wr            = ld_data && bs_first && is_wr_flash;   // [RULE21]

   always_ff @(posedge clk) begin
      if (clr) begin
         for (int i = 0; i < `PPL_FIFO_DEPTH; i++) begin
            page_buf[i] <= `PPL_RST_WORD;
         end
      end else if (buf_wr) begin
         page_buf[page_word_index] <= {bus, data_lo}; // [RULE21]
      end
   end

   // ==========================================================
   // operation sequencer
   // ==========================================================
   ppl_state_t state;
   ppl_state_t next_state;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic       erase_pend;
   logic       next_erase_pend;

   logic        push_valid;
   logic [2:0]  push_op;
   logic [9:0]  push_addr;
   logic [15:0] push_data;
   wire         push_ready;

   // erase of data memory is skipped when the preserve fuse is programmed (low)
   wire ee_erase = keep_nvdata_fuse; // [RULE19]

   wire start_page  = wr_fall && is_wr_flash && !bs_first; // [RULE24]
   wire start_erase = wr_fall && is_erase;                 // [RULE6]
   wire start_misc  = wr_fall && (is_wr_fuse || is_wr_lock || is_wr_ee);

   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_erase_pend = erase_pend;
      push_valid      = 1'b0;
      push_op         = PPL_OP_FLASH_WORD;
      push_addr       = '0;
      push_data       = '0;
      case (state)
         PPL_ST_IDLE: begin
            next_cnt = '0;
            if (start_page) begin
               next_state = PPL_ST_PAGE;
            end else if (start_erase) begin
               next_state      = PPL_ST_ERASE;
               next_erase_pend = 1'b1;
            end else if (start_misc) begin
               push_valid = 1'b1;
               push_addr  = {addr_hi, addr_lo};
               push_data  = {8'h00, data_lo};
               if (is_wr_lock) begin
                  push_op = PPL_OP_LOCK_WR;
               end else if (is_wr_ee) begin
                  push_op = PPL_OP_EE_BYTE;
               end else if (bs_first) begin
                  push_op = PPL_OP_FUSE_HI;
               end else begin
                  push_op = PPL_OP_FUSE_LO;
               end
               // fifo is empty when idle, so the push always lands
               next_state = PPL_ST_DRAIN;
            end
         end
         PPL_ST_PAGE: begin
            // whole buffered page streamed as one operation
            push_valid = 1'b1;                                       // [RULE21] [RULE24]
            push_op    = PPL_OP_FLASH_WORD;
            push_addr  = {page_number_index, cnt[`PPL_WORD_IDX_MSB:0]}; // [RULE23]
            push_data  = page_buf[cnt[`PPL_WORD_IDX_MSB:0]];
            if (push_ready) begin
               next_cnt = cnt + 5'h01;
               if (next_cnt == `PPL_PAGE_WORDS) begin
                  next_state = PPL_ST_DRAIN;
               end
            end
         end
         PPL_ST_ERASE: begin
            push_valid = 1'b1;
            push_op    = (cnt == 5'h00) ? PPL_OP_ERASE_FLASH : PPL_OP_ERASE_EE; // [RULE18]
            if (push_ready) begin
               next_cnt = cnt + 5'h01;
               if (cnt != 5'h00 || !ee_erase) begin
                  next_state = PPL_ST_DRAIN; // [RULE19]
               end
            end
         end
         PPL_ST_DRAIN: begin
            // memory must be fully done before lock bits may clear
            if (!nvm_valid && nvm_idle) begin
               next_state = erase_pend ? PPL_ST_LOCK : PPL_ST_IDLE; // [RULE18]
            end
         end
         PPL_ST_LOCK: begin
            push_valid = 1'b1;
            push_op    = PPL_OP_LOCK_CLEAR; // [RULE18]
            if (push_ready) begin
               next_erase_pend = 1'b0;
               next_state      = PPL_ST_DRAIN;
            end
         end
         default: begin
            next_state = PPL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (clr) begin
         state      <= PPL_ST_IDLE;
         cnt        <= '0;
         erase_pend <= 1'b0;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         erase_pend <= next_erase_pend;
      end
   end

   // busy from the write pulse edge until everything has landed
   always_ff @(posedge clk) begin
      if (clr) begin
         ready_busy_flag <= 1'b1;
      end else begin
         ready_busy_flag <= (next_state == PPL_ST_IDLE); // [RULE6] [RULE24] [RULE25]
      end
   end

   // ==========================================================
   // write queue toward the memory
   // ==========================================================
   // the 16-deep queue holds a whole page, so nvm_ready back-pressure never stalls the page streaming above
   ppl_fifo #(
      .WIDTH (`PPL_FIFO_WIDTH),
      .DEPTH (`PPL_FIFO_DEPTH)
   ) u_ppl_fifo (
      .clk       (clk),
      .rst_n     (!clr),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   ({push_op, push_addr, push_data}),
      .out_valid (nvm_valid),
      .out_ready (nvm_ready),
      .out_data  ({nvm_op, nvm_addr, nvm_data})
   );

   // ==========================================================
   // read path
   // ==========================================================
   assign rd_addr       = {addr_hi, addr_lo};
   assign rd_high       = bs_first;
   // only meaningful during fuse reads with no strobe
   assign rd_sel_second = bs_second;
   assign cmd_code      = cmd;

   wire drive = in_mode && !oe_n_s && is_read;

   always_ff @(posedge clk) begin
      if (clr) begin
         data_out  <= 8'h00;
         data_oe_n <= 1'b1;
      end else begin
         data_out  <= drive ? rd_data : 8'h00;
         data_oe_n <= !drive;
      end
   end

endmodule : ppl_loader

`default_nettype wire

// ===== ppl_loader_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppl_regs.svh"

module ppl_loader_chk
   import ppl_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        prog_mode_pin,
   input wire logic        load_strobe_pin,
   input wire logic        write_pulse_n,
   input wire logic        keep_nvdata_fuse,
   input wire logic [7:0]  data_out,
   input wire logic        data_oe_n,
   input wire logic        ready_busy_flag,
   input wire logic [9:0]  rd_addr,
   input wire logic [7:0]  cmd_code,
   input wire logic        nvm_valid,
   input wire logic [2:0]  nvm_op,
   input wire logic [9:0]  nvm_addr,
   input wire logic        nvm_idle
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==================================================
   // quiet time since the last strobe or mode drop
   logic [3:0] quiet;
   always_ff @(posedge clk) begin
      if (!rst_n || load_strobe_pin || !prog_mode_pin) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
   end

   sequence s_erase_start;
      $fell(write_pulse_n) && ready_busy_flag && cmd_code == `PPL_CMD_CHIP_ERASE;
   endsequence
   sequence s_busy_low;
      !ready_busy_flag;
   endsequence

   // ==================================================
   regs_hold_a: assert property (quiet >= 4'h6 |-> $stable(cmd_code) && $stable(rd_addr))
      else $error("registers changed without a strobe");
   erase_busy_a: assert property (s_erase_start |-> ##[3:5] s_busy_low)
      else $error("erase did not raise busy");
   ops_busy_a: assert property (nvm_valid |-> !ready_busy_flag)
      else $error("ready while ops pending");
   ready_idle_a: assert property ($rose(ready_busy_flag) |-> $past(nvm_idle))
      else $error("ready before memory idle");
   busy_bound_a: assert property ($fell(ready_busy_flag) |-> ##[1:400] ready_busy_flag)
      else $error("busy never ended");
   erase_ops_a: assert property (nvm_valid && cmd_code == `PPL_CMD_CHIP_ERASE
      |-> nvm_op inside {PPL_OP_ERASE_FLASH, PPL_OP_ERASE_EE, PPL_OP_LOCK_CLEAR})
      else $error("bad erase op");
   keep_ee_a: assert property (nvm_valid && cmd_code == `PPL_CMD_CHIP_ERASE && !keep_nvdata_fuse
      |-> nvm_op != PPL_OP_ERASE_EE)
      else $error("data memory erased while preserved");
   lock_late_a: assert property ($rose(nvm_valid) && nvm_op == PPL_OP_LOCK_CLEAR |-> $past(nvm_idle))
      else $error("lock clear before erase done");
   page_addr_a: assert property (nvm_valid && cmd_code == `PPL_CMD_WR_FLASH
      |-> nvm_op == PPL_OP_FLASH_WORD && nvm_addr[9:4] == rd_addr[9:4])
      else $error("page op with wrong page");
   read_cmd_a: assert property (!data_oe_n |-> $past(cmd_code) inside {8'h02, 8'h03, 8'h04, 8'h08})
      else $error("drive without read command");
   idle_zero_a: assert property (data_oe_n |-> data_out == 8'h00)
      else $error("data out not zero");
endmodule : ppl_loader_chk

bind ppl_loader ppl_loader_chk u_ppl_loader_chk (
   .clk(clk), .rst_n(rst_n), .prog_mode_pin(prog_mode_pin), .load_strobe_pin(load_strobe_pin),
   .write_pulse_n(write_pulse_n), .keep_nvdata_fuse(keep_nvdata_fuse), .data_out(data_out),
   .data_oe_n(data_oe_n), .ready_busy_flag(ready_busy_flag), .rd_addr(rd_addr), .cmd_code(cmd_code),
   .nvm_valid(nvm_valid), .nvm_op(nvm_op), .nvm_addr(nvm_addr), .nvm_idle(nvm_idle));

`default_nettype wire

// ===== ppl_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module ppl_mem_model (
   input  wire logic        clk,
   input  wire logic        nvm_valid,
   output logic             nvm_ready,
   input  wire logic [2:0]  nvm_op,
   input  wire logic [9:0]  nvm_addr,
   input  wire logic [15:0] nvm_data,
   output logic             nvm_idle,
   input  wire logic [9:0]  rd_addr,
   input  wire logic        rd_high,
   output logic      [7:0]  rd_data
);
   logic [2:0]  lop [64];
   logic [9:0]  la  [64];
   logic [15:0] ld  [64];
   int          n = 0;
   logic [1:0]  cnt = 2'h0;

   // ==================================================
   // stalls every other cycle so entries back up in the buffer
   initial nvm_ready = 1'b0;
   always @(posedge clk) begin
      nvm_ready <= ~nvm_ready;
      if (nvm_valid && nvm_ready) begin
         lop[n] <= nvm_op;
         la[n] <= nvm_addr;
         ld[n] <= nvm_data;
         n <= n + 1;
         cnt <= 2'h3;
      end else if (cnt != 2'h0) cnt <= cnt - 2'h1;
   end
   assign nvm_idle = (cnt == 2'h0);
   assign rd_data = rd_high ? ~rd_addr[7:0] : rd_addr[7:0];
endmodule : ppl_mem_model

`default_nettype wire

// ===== parallel_program_loader_test.sv
`timescale 1ns/1ps
`default_nettype none

module parallel_program_loader_test;
   logic clk = 0, rst_n = 0, prog_mode_pin = 0, load_strobe_pin = 0;
   logic action_select_hi = 1, action_select_lo = 1, byte_select_first = 0;
   logic write_pulse_n = 1, output_enable_n = 1, keep_nvdata_fuse = 1;
   logic [7:0]  data_in = 8'h00, data_out, cmd_code, rd_data;
   logic        data_oe_n, ready_busy_flag, rd_high, rd_sel_second, nvm_valid, nvm_ready, nvm_idle;
   logic [9:0]  rd_addr, nvm_addr;
   logic [2:0]  nvm_op;
   logic [15:0] nvm_data;
   int          bad_count = 0, checks = 0, i, b;
   logic [7:0]  codes [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h11, 8'h08, 8'h04, 8'h02, 8'h03};
   // fuse low, fuse high, lock, data memory byte
   logic [7:0]  wcmd [4] = '{8'h40, 8'h40, 8'h20, 8'h11}, wdat [4] = '{8'hE4, 8'hDF, 8'hFC, 8'h5A};

   ppl_loader u_ppl_loader (.clk(clk), .rst_n(rst_n), .prog_mode_pin(prog_mode_pin),
      .load_strobe_pin(load_strobe_pin), .action_select_hi(action_select_hi),
      .action_select_lo(action_select_lo), .byte_select_first(byte_select_first),
      .write_pulse_n(write_pulse_n), .output_enable_n(output_enable_n), .data_in(data_in),
      .data_out(data_out), .data_oe_n(data_oe_n), .ready_busy_flag(ready_busy_flag),
      .keep_nvdata_fuse(keep_nvdata_fuse), .rd_addr(rd_addr), .rd_high(rd_high),
      .rd_sel_second(rd_sel_second), .cmd_code(cmd_code), .rd_data(rd_data), .nvm_valid(nvm_valid),
      .nvm_ready(nvm_ready), .nvm_op(nvm_op), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
      .nvm_idle(nvm_idle));
   ppl_mem_model u_ppl_mem_model (.clk(clk), .nvm_valid(nvm_valid), .nvm_ready(nvm_ready),
      .nvm_op(nvm_op), .nvm_addr(nvm_addr), .nvm_data(nvm_data), .nvm_idle(nvm_idle),
      .rd_addr(rd_addr), .rd_high(rd_high), .rd_data(rd_data));

   initial forever #12.5 clk = ~clk;

   // ==================================================
   task automatic give_verdict;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc

   // strobe held 3 cycles each way to clear the input synchronisers
   task automatic ld(input logic [1:0] a, input logic bs, input logic [7:0] d);
      {action_select_hi, action_select_lo} = a;
      byte_select_first = bs;
      data_in = d;
      cyc(1);
      load_strobe_pin = 1;
      cyc(3);
      load_strobe_pin = 0;
      cyc(3);
      {action_select_hi, action_select_lo} = 2'h3;
      // idle one cycle so the next call never reassigns in this time step
      cyc(1);
   endtask : ld

   task automatic wr(input logic bs, input logic exp_rdy);
      int k;
      byte_select_first = bs;
      cyc(1);
      write_pulse_n = 0;
      cyc(5);
      chk(ready_busy_flag, exp_rdy);
      write_pulse_n = 1;
      for (k = 0; k < 400 && ready_busy_flag !== 1'b1; k++) cyc(1);
      if (k == 400) begin
         bad_count++;
         give_verdict();
      end
   endtask : wr

   // ==================================================
   initial begin
      cyc(5);
      rst_n = 1;
      chk(ready_busy_flag, 1);
      chk(data_oe_n, 1);
      prog_mode_pin = 1;
      cyc(4);
      foreach (codes[k]) begin
         ld(2'h2, 0, codes[k]);
         chk(cmd_code, codes[k]);
      end
      ld(2'h3, 0, 8'h55);
      chk(cmd_code, 8'h03);
      $display("command test done");

      for (i = 0; i < 2; i++) begin
         keep_nvdata_fuse = i[0];
         b = u_ppl_mem_model.n;
         ld(2'h2, 0, 8'h80);
         wr(0, 0);
         chk(u_ppl_mem_model.n - b, 2 + i);
         chk(u_ppl_mem_model.lop[b], 3'h1);
         chk(u_ppl_mem_model.lop[b+1+i], 3'h3);
      end
      $display("erase test done");

      for (i = 0; i < 4; i++) begin
         b = u_ppl_mem_model.n;
         ld(2'h2, 0, wcmd[i]);
         ld(2'h1, 0, wdat[i]);
         wr(i == 1, 0);
         chk(u_ppl_mem_model.n - b, 1);
         chk(u_ppl_mem_model.lop[b], 3'h4 + i[2:0]);
         chk(u_ppl_mem_model.ld[b], {8'h00, wdat[i]});
      end
      $display("byte write test done");

      ld(2'h2, 0, 8'h10);
      ld(2'h0, 1, 8'hFE);
      chk(rd_addr[9:8], 2'h2);
      b = u_ppl_mem_model.n;
      for (i = 0; i < 16; i++) begin
         ld(2'h0, 0, {4'h5, i[3:0]});
         ld(2'h1, 0, {4'h5, i[3:0]});
         ld(2'h1, 1, {4'hA, i[3:0]});
      end
      chk(rd_addr, 10'h25F);
      wr(1, 1);
      wr(0, 0);
      chk(u_ppl_mem_model.n - b, 16);
      for (i = 0; i < 16; i++) begin
         chk(u_ppl_mem_model.la[b+i], {2'h2, 4'h5, i[3:0]});
         chk(u_ppl_mem_model.ld[b+i], {4'hA, i[3:0], 4'h5, i[3:0]});
      end
      chk(cmd_code, 8'h10);
      $display("page test done");

      ld(2'h2, 0, 8'h02);
      ld(2'h0, 1, 8'h01);
      ld(2'h0, 0, 8'h3C);
      output_enable_n = 0;
      cyc(5);
      chk(data_oe_n, 0);
      chk(data_out, 8'h3C);
      byte_select_first = 1;
      cyc(5);
      chk(data_out, 8'hC3);
      output_enable_n = 1;
      cyc(5);
      chk(data_oe_n, 1);
      ld(2'h2, 0, 8'h40);
      output_enable_n = 0;
      cyc(5);
      chk(data_oe_n, 1);
      output_enable_n = 1;
      // second byte select follows the action high pin; checked here with output enable low and no strobe
      ld(2'h2, 0, 8'h04);
      byte_select_first = 1;
      output_enable_n = 0;
      cyc(5);
      chk(data_oe_n, 0);
      chk(data_out, 8'hC3);
      chk(rd_sel_second, 1);
      action_select_hi = 0;
      cyc(5);
      chk(rd_sel_second, 0);
      chk(cmd_code, 8'h04);
      output_enable_n = 1;
      action_select_hi = 1;
      $display("read test done");

      prog_mode_pin = 0;
      cyc(5);
      chk(cmd_code, 8'h00);
      chk(rd_addr, 10'h000);
      prog_mode_pin = 1;
      cyc(4);
      chk(ready_busy_flag, 1);
      $display("mode test done");
      give_verdict();
   end

   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
endmodule : parallel_program_loader_test

`default_nettype wire
